// File: rtl/umcls_line_status.sv
// Modem control, line status and receiver with a classic Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "umcls_defines.svh"

module umcls_line_status (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic      [31:0] wb_dat_o,
	input  wire logic        baudTick,
	input  wire logic        txSerialIn,
	input  wire logic        txHoldEmpty,
	input  wire logic        txShiftEmpty,
	input  wire logic        txIdle,
	input  wire logic        txBreak,
	input  wire logic        rxdPin,
	input  wire logic        ctsPinN,
	input  wire logic        dsrPinN,
	input  wire logic        dcdPinN,
	input  wire logic        riPinN,
	output logic             txdPin,
	output logic             rtsPinN,
	output logic             dtrPinN,
	output logic             uartShutdown,
	output logic             multidropMode
);

	umcls_pkg::umcls_state_s st_reg;
	umcls_pkg::umcls_state_s st_next;

	logic        access;
	logic        wrEn;
	logic        lsrRead;
	logic        rbrRead;
	logic        echo;
	logic        rxLine;
	logic        pushValid;
	logic [10:0] pushData;
	logic        overrunEvt;
	logic        fullEff;
	logic [2:0]  lastIdx;
	logic [7:0]  lsrVal;
	logic [2:0]  topErr;
	logic        parMiss;
	logic        stopLow;
	logic [10:0] topData;
	logic        fifoEmpty;
	logic        fifoFull;
	logic        fifoErrAny;

	umcls_rx_fifo rxFifo (
		.clk       (clk),
		.resetn    (resetn),
		.flush     (st_reg.mcr[`UMCLS_MCR_SHUTDOWN]),
		.pushValid (pushValid),
		.pushData  (pushData),
		.popReq    (rbrRead),
		.topData   (topData),
		.empty     (fifoEmpty),
		.full      (fifoFull),
		.errAny    (fifoErrAny)
	);

	always_comb begin
		st_next = st_reg;
		access = wb_cyc_i && wb_stb_i && !st_reg.wbAck;
		wrEn = access && wb_we_i && wb_sel_i[0];
		lsrRead = access && !wb_we_i && (wb_adr_i == `UMCLS_OFS_LSR);
		rbrRead = access && !wb_we_i && (wb_adr_i == `UMCLS_OFS_RBR);
		echo = st_reg.mcr[`UMCLS_MCR_ECHO];
		pushValid = 1'b0;
		pushData = 11'h000;
		overrunEvt = 1'b0;
		parMiss = 1'b0;
		stopLow = 1'b0;
		lastIdx = 3'(`UMCLS_BITS_MIN + {1'b0, st_reg.fmt[1:0]});
		// Without FIFO the buffer holds a single character
		fullEff = st_reg.fmt[`UMCLS_FMT_FIFO_EN] ? fifoFull
			: !fifoEmpty;

		// Pin inputs: a rise counts once the second and third stages agree, a fall as soon as the second stage falls
		st_next.sync1 = {riPinN, dcdPinN, dsrPinN, ctsPinN, rxdPin};
		st_next.sync2 = st_reg.sync1;
		st_next.sync3 = st_reg.sync2;
		st_next.filt = (st_reg.sync2 & st_reg.sync3)
			| (st_reg.filt & ~(st_reg.sync2 ^ st_reg.sync3));

		// Receive source: internal transmit stream in echo mode
		if (echo) begin
			rxLine = txSerialIn;
		end else begin
			rxLine = st_reg.filt[0] ^ st_reg.mcr[`UMCLS_MCR_INVERT];
		end

		// Modem status as {carrier, ring, dsr, cts}
		if (echo) begin
			st_next.modemStat = {st_reg.mcr[`UMCLS_MCR_AUXB],
				st_reg.mcr[`UMCLS_MCR_AUXA],
				st_reg.mcr[`UMCLS_MCR_DTR],
				st_reg.mcr[`UMCLS_MCR_RTS]};
		end else begin
			st_next.modemStat = ~{st_reg.filt[3], st_reg.filt[4],
				st_reg.filt[2], st_reg.filt[1]};
		end

		// Line side outputs
		st_next.txd = (echo ? 1'b1 : txSerialIn)
			^ st_reg.mcr[`UMCLS_MCR_INVERT];
		st_next.rtsN = echo ? 1'b1 : !st_reg.mcr[`UMCLS_MCR_RTS];
		st_next.dtrN = echo ? 1'b1 : !st_reg.mcr[`UMCLS_MCR_DTR];
		st_next.shutdown = st_reg.mcr[`UMCLS_MCR_SHUTDOWN];
		st_next.multidrop = st_reg.mcr[`UMCLS_MCR_MDROP];

		// Transmit status, forced low during a break command
		st_next.txAllIdle = txHoldEmpty && txShiftEmpty && txIdle
			&& !txBreak;
		st_next.txVacant = txHoldEmpty && !txBreak;

		// Receiver, sixteen ticks per bit, samples in the bit middle
		case (st_reg.rxState)
			umcls_pkg::RX_IDLE: begin
				st_next.ovsCnt = 4'h0;
				if (!rxLine) begin
					st_next.rxState = umcls_pkg::RX_START;
				end
			end
			umcls_pkg::RX_START: begin
				if (baudTick) begin
					st_next.ovsCnt = st_reg.ovsCnt + 4'h1;
					if (st_reg.ovsCnt == `UMCLS_OVS_MID) begin
						st_next.ovsCnt = 4'h0;
						st_next.bitIdx = 3'h0;
						st_next.shift = 8'h00;
						st_next.parAcc = 1'b0;
						st_next.allZero = 1'b1;
						st_next.parErr = 1'b0;
						st_next.rxState = rxLine ? umcls_pkg::RX_IDLE
							: umcls_pkg::RX_DATA;
					end
				end
			end
			umcls_pkg::RX_DATA: begin
				if (baudTick) begin
					st_next.ovsCnt = st_reg.ovsCnt + 4'h1;
					if (st_reg.ovsCnt == `UMCLS_OVS_LAST) begin
						st_next.shift[st_reg.bitIdx] = rxLine;
						st_next.parAcc = st_reg.parAcc ^ rxLine;
						st_next.allZero = st_reg.allZero && !rxLine;
						st_next.bitIdx = st_reg.bitIdx + 3'h1;
						if (st_reg.bitIdx == lastIdx) begin
							st_next.rxState =
								st_reg.fmt[`UMCLS_FMT_PAR_EN]
								? umcls_pkg::RX_PARITY
								: umcls_pkg::RX_STOP;
						end
					end
				end
			end
			umcls_pkg::RX_PARITY: begin
				if (baudTick) begin
					st_next.ovsCnt = st_reg.ovsCnt + 4'h1;
					if (st_reg.ovsCnt == `UMCLS_OVS_LAST) begin
						// Even parity: data plus parity bit hold even ones
						parMiss = (st_reg.parAcc ^ rxLine)
							^ !st_reg.fmt[`UMCLS_FMT_PAR_EVEN];
						// Multi-drop uses the parity bit as an address mark
						st_next.parErr = parMiss
							&& !st_reg.mcr[`UMCLS_MCR_MDROP];
						st_next.allZero = st_reg.allZero && !rxLine;
						st_next.rxState = umcls_pkg::RX_STOP;
					end
				end
			end
			umcls_pkg::RX_STOP: begin
				if (baudTick) begin
					st_next.ovsCnt = st_reg.ovsCnt + 4'h1;
					if (st_reg.ovsCnt == `UMCLS_OVS_LAST) begin
						stopLow = !rxLine;
						if (stopLow && st_reg.allZero) begin
							// Whole character time low: one null entry
							pushData = 11'h000;
							pushData[`UMCLS_ENT_BRK] = 1'b1;
							pushData[`UMCLS_ENT_FE] = 1'b1;
							st_next.rxState = umcls_pkg::RX_BREAK;
						end else begin
							pushData = {1'b0, stopLow, st_reg.parErr,
								st_reg.shift};
							// Low stop bit: wait for mark, else a false start
							st_next.rxState = stopLow
								? umcls_pkg::RX_BREAK
								: umcls_pkg::RX_IDLE;
						end
						// Full buffer: character stays behind and is lost
						pushValid = !fullEff;
						overrunEvt = fullEff;
					end
				end
			end
			umcls_pkg::RX_BREAK: begin
				// No further entries until the line returns high
				if (rxLine) begin
					st_next.rxState = umcls_pkg::RX_IDLE;
				end
			end
			default: begin
				st_next.rxState = umcls_pkg::RX_IDLE;
			end
		endcase

		// Error bits of the entry at the read position
		topErr = fifoEmpty ? 3'h0
			: topData[`UMCLS_ENT_BRK:`UMCLS_ENT_PE];
		lsrVal = 8'h00;
		lsrVal[7] = st_reg.fault;
		lsrVal[6] = st_reg.txAllIdle;
		lsrVal[5] = st_reg.txVacant;
		lsrVal[4:2] = topErr;
		lsrVal[1] = st_reg.overflow;
		lsrVal[0] = !fifoEmpty;

		// Sticky flags: a new event wins over the clearing read
		st_next.fault = fifoErrAny
			|| (st_reg.fault && !lsrRead);
		st_next.overflow = overrunEvt
			|| (st_reg.overflow && !lsrRead);

		// Register writes
		if (wrEn) begin
			if (wb_adr_i == `UMCLS_OFS_MCR) begin
				st_next.mcr = wb_dat_i[7:0];
			end else if (wb_adr_i == `UMCLS_OFS_FMT) begin
				st_next.fmt = wb_dat_i[5:0];
			end
		end

		// Register reads; unmapped addresses answer zero
		st_next.wbAck = access;
		if (access && !wb_we_i) begin
			st_next.wbDat = 32'h0000_0000;
			if (wb_adr_i == `UMCLS_OFS_RBR) begin
				st_next.wbDat[7:0] = fifoEmpty ? 8'h00 : topData[7:0];
			end else if (wb_adr_i == `UMCLS_OFS_FMT) begin
				st_next.wbDat[5:0] = st_reg.fmt;
			end else if (wb_adr_i == `UMCLS_OFS_MCR) begin
				st_next.wbDat[7:0] = st_reg.mcr;
			end else if (wb_adr_i == `UMCLS_OFS_LSR) begin
				st_next.wbDat[7:0] = lsrVal;
			end else if (wb_adr_i == `UMCLS_OFS_MSR) begin
				st_next.wbDat[7:4] = st_reg.modemStat;
			end
		end

		// Shutdown holds receiver idle and status cleared
		if (st_reg.mcr[`UMCLS_MCR_SHUTDOWN]) begin
			st_next.rxState = umcls_pkg::RX_IDLE;
			st_next.ovsCnt = 4'h0;
			st_next.fault = 1'b0;
			st_next.overflow = 1'b0;
			pushValid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.mcr <= `UMCLS_MCR_RESET;
			st_reg.fmt <= `UMCLS_FMT_RESET;
			st_reg.txAllIdle <= 1'b1;
			st_reg.txVacant <= 1'b1;
			st_reg.txd <= 1'b1;
			st_reg.rtsN <= 1'b1;
			st_reg.dtrN <= 1'b1;
			st_reg.sync1 <= `UMCLS_PIN_IDLE;
			st_reg.sync2 <= `UMCLS_PIN_IDLE;
			st_reg.sync3 <= `UMCLS_PIN_IDLE;
			st_reg.filt <= `UMCLS_PIN_IDLE;
			st_reg.rxState <= umcls_pkg::RX_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_ack_o = st_reg.wbAck;
	assign wb_dat_o = st_reg.wbDat;
	assign txdPin = st_reg.txd;
	assign rtsPinN = st_reg.rtsN;
	assign dtrPinN = st_reg.dtrN;
	assign uartShutdown = st_reg.shutdown;
	assign multidropMode = st_reg.multidrop;

endmodule
`default_nettype wire

// File: rtl/umcls_defines.svh
// Constants for the UART modem control and line status block
// Operation
// - While shutdown is set, FIFOs, receiver state and status flags are cleared.
// - Line invert flips the polarity of serial transmit and receive.
// - Multi-drop enable selects multi-drop mode; it resets to zero.
// - Echo mode feeds the receiver from the internal transmit stream.
// - Echo mode ignores modem inputs; low control bits drive modem status.
// - Echo mode holds the RTS and DTR pins inactive.
// - In echo mode aux_out_b shows as carrier detect, aux_out_a as ring.
// - RTS pin is the inverse of its bit; in echo it feeds CTS status.
// - DTR pin is the inverse of its bit; in echo it feeds DSR status.
// - FIFO fault summary sets while any stored entry carries an error.
// - Status read clears the summary only when no stored entry has error.
// - All-idle sets only with holding, shift register empty and idle.
// - During a transmit break both transmit empty flags stay zero.
// - Holding-vacant sets when holding register or FIFO is empty.
// - Break seen when receive line stays low a full character time.
// - Each break loads one null entry with framing error into the FIFO.
// - Stop-bit fault flags a low stop bit; it follows the top entry.
// - Parity fault shows a parity mismatch of the top entry.
// - Without FIFO, a character arriving before the last was read overflows.
// - With full FIFO a new character is dropped, overflow set, read clears.
// - Receive available sets when a character enters the buffer or FIFO.
`ifndef UMCLS_DEFINES_SVH
`define UMCLS_DEFINES_SVH

`define UMCLS_OFS_RBR       8'h00
`define UMCLS_OFS_FMT       8'h0C
`define UMCLS_OFS_MCR       8'h10
`define UMCLS_OFS_LSR       8'h14
`define UMCLS_OFS_MSR       8'h18

`define UMCLS_MCR_SHUTDOWN  7
`define UMCLS_MCR_INVERT    6
`define UMCLS_MCR_MDROP     5
`define UMCLS_MCR_ECHO      4
`define UMCLS_MCR_AUXB      3
`define UMCLS_MCR_AUXA      2
`define UMCLS_MCR_RTS       1
`define UMCLS_MCR_DTR       0
`define UMCLS_MCR_RESET     8'h00

`define UMCLS_FMT_PAR_EN    3
`define UMCLS_FMT_PAR_EVEN  4
`define UMCLS_FMT_FIFO_EN   5
`define UMCLS_FMT_RESET     6'h03

`define UMCLS_ENT_BRK       10
`define UMCLS_ENT_FE        9
`define UMCLS_ENT_PE        8
`define UMCLS_FIFO_DEPTH    5'h10

`define UMCLS_OVS_MID       4'h7
`define UMCLS_OVS_LAST      4'hF
`define UMCLS_BITS_MIN      3'h4
`define UMCLS_PIN_IDLE      5'h1F

`endif

// File: rtl/umcls_pkg.sv
// Types of the UART modem control and line status block
package umcls_pkg;

	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK
	} umcls_rx_e;

	typedef struct packed {
		logic [15:0][10:0] mem;
		logic [3:0]        wrPtr;
		logic [3:0]        rdPtr;
		logic [4:0]        count;
		logic [4:0]        errCount;
	} umcls_fifo_s;

	typedef struct packed {
		logic        wbAck;
		logic [31:0] wbDat;
		logic [7:0]  mcr;
		logic [5:0]  fmt;
		logic [3:0]  modemStat;
		logic        fault;
		logic        overflow;
		logic        txAllIdle;
		logic        txVacant;
		logic        txd;
		logic        rtsN;
		logic        dtrN;
		logic        shutdown;
		logic        multidrop;
		logic [4:0]  sync1;
		logic [4:0]  sync2;
		logic [4:0]  sync3;
		logic [4:0]  filt;
		umcls_rx_e   rxState;
		logic [3:0]  ovsCnt;
		logic [2:0]  bitIdx;
		logic [7:0]  shift;
		logic        parAcc;
		logic        allZero;
		logic        parErr;
	} umcls_state_s;

endpackage

// File: rtl/umcls_rx_fifo.sv
// Receive FIFO holding characters with their error bits
`timescale 1ns/1ps
`default_nettype none
`include "umcls_defines.svh"

module umcls_rx_fifo (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        flush,
	input  wire logic        pushValid,
	input  wire logic [10:0] pushData,
	input  wire logic        popReq,
	output logic      [10:0] topData,
	output logic             empty,
	output logic             full,
	output logic             errAny
);

	umcls_pkg::umcls_fifo_s fifo_reg;
	umcls_pkg::umcls_fifo_s fifo_next;
	logic                   doPush;
	logic                   doPop;
	logic                   pushErr;
	logic                   popErr;

	always_comb begin
		fifo_next = fifo_reg;
		doPush = pushValid && (fifo_reg.count != `UMCLS_FIFO_DEPTH);
		doPop = popReq && (fifo_reg.count != 5'h00);
		pushErr = doPush && (|pushData[`UMCLS_ENT_BRK:`UMCLS_ENT_PE]);
		popErr = doPop &&
			(|fifo_reg.mem[fifo_reg.rdPtr][`UMCLS_ENT_BRK:`UMCLS_ENT_PE]);
		if (doPush) begin
			fifo_next.mem[fifo_reg.wrPtr] = pushData;
			fifo_next.wrPtr = fifo_reg.wrPtr + 4'h1;
		end
		if (doPop) begin
			fifo_next.rdPtr = fifo_reg.rdPtr + 4'h1;
		end
		fifo_next.count = fifo_reg.count + {4'h0, doPush} - {4'h0, doPop};
		// Count of stored entries with any error drives the summary flag
		fifo_next.errCount = fifo_reg.errCount + {4'h0, pushErr}
			- {4'h0, popErr};
		if (flush) begin
			fifo_next.wrPtr = 4'h0;
			fifo_next.rdPtr = 4'h0;
			fifo_next.count = 5'h00;
			fifo_next.errCount = 5'h00;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fifo_reg <= '0;
		end else begin
			fifo_reg <= fifo_next;
		end
	end

	assign topData = fifo_reg.mem[fifo_reg.rdPtr];
	assign empty = (fifo_reg.count == 5'h00);
	assign full = (fifo_reg.count == `UMCLS_FIFO_DEPTH);
	assign errAny = (fifo_reg.errCount != 5'h00);

endmodule
`default_nettype wire

// File: verification/umcls_line_status_chk.sv
// Port assertions for the modem control and line status block
`timescale 1ns/1ps
`default_nettype none
module umcls_line_status_chk (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        txSerialIn,
	input wire logic        txBreak,
	input wire logic        txdPin,
	input wire logic        rtsPinN,
	input wire logic        dtrPinN,
	input wire logic        uartShutdown,
	input wire logic        multidropMode
);
	logic [7:0] ctl;
	logic       rdAck;
	// Control value as last accepted over the bus
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			ctl <= 8'h00;
		else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h10)
			ctl <= wb_dat_i[7:0];
	end
	assign rdAck = wb_ack_o && !wb_we_i;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in the next cycle");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("reserved read bits not zero");
	rts_level_a: assert property (rtsPinN == (ctl[4] | !ctl[1]))
		else $error("rts pin level wrong");
	dtr_level_a: assert property (dtrPinN == (ctl[4] | !ctl[0]))
		else $error("dtr pin level wrong");
	ctl_copy_a: assert property (uartShutdown == ctl[7] && multidropMode == ctl[5])
		else $error("shutdown or multidrop output wrong");
	txd_level_a: assert property (txdPin == (ctl[4] ? !ctl[6] : $past(txSerialIn) ^ ctl[6]))
		else $error("serial output level wrong");
	tx_break_a: assert property (rdAck && wb_adr_i == 8'h14 && txBreak && $past(txBreak) && $past(txBreak, 2) |-> wb_dat_o[6:5] == 2'b00)
		else $error("transmit empty flags set during break");
	lsr_summary_a: assert property (rdAck && wb_adr_i == 8'h14 && |wb_dat_o[4:2] |-> wb_dat_o[7])
		else $error("top entry error without fault summary");
	msr_echo_a: assert property (rdAck && wb_adr_i == 8'h18 && ctl[4] && ctl == $past(ctl, 4) |-> wb_dat_o[7:4] == {ctl[3], ctl[2], ctl[0], ctl[1]})
		else $error("modem status in echo mode wrong");
endmodule
bind umcls_line_status umcls_line_status_chk i_chk (
	.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_ack_o, .wb_dat_o, .txSerialIn, .txBreak, .txdPin,
	.rtsPinN, .dtrPinN, .uartShutdown, .multidropMode
);
`default_nettype wire

// File: verification/umcls_remote_model.sv
// Remote serial sender shifting one frame out LSB first at 16 ticks a bit
`timescale 1ns/1ps
`default_nettype none
module umcls_remote_model (
	input  wire logic        clk,
	input  wire logic        baudTick,
	input  wire logic        inv,
	input  wire logic        go,
	input  wire logic [13:0] frame,
	input  wire logic [3:0]  nBits,
	output logic             line,
	output logic             busy
);
	logic [13:0] sr = 14'h0;
	logic [3:0]  left = 4'h0;
	logic [3:0]  tick = 4'h0;
	initial busy = 1'b0;
	always @(posedge clk) begin
		if (go && !busy) begin
			sr <= frame;
			left <= nBits;
			tick <= 4'h0;
			busy <= 1'b1;
		end else if (busy && baudTick) begin
			tick <= tick + 4'h1;
			if (tick == 4'hF) begin
				sr <= {1'b1, sr[13:1]};
				left <= left - 4'h1;
				if (left == 4'h1)
					busy <= 1'b0;
			end
		end
	end
	// Mark level between frames
	assign line = (busy ? sr[0] : 1'b1) ^ inv;
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the modem control and line status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0, resetn = 1'b0, baudTick = 1'b0;
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbDatW = 32'h0, wbDatR;
	logic [3:0]  txSt = 4'hE;
	logic [3:0]  modemN = 4'h7;
	logic        route = 1'b0, inv = 1'b0, go = 1'b0, line, busy;
	logic        rxd, txIn, txdPin, rtsPinN, dtrPinN, shut, mdrop;
	logic [13:0] frame = 14'h0;
	logic [3:0]  nBits = 4'h0;
	logic [3:0]  txCase [5] = '{4'h6, 4'hA, 4'hC, 4'hF, 4'hE};
	logic [31:0] txExp [5] = '{32'h00, 32'h20, 32'h20, 32'h00, 32'h60};
	logic [7:0]  ctlSet [7] = '{8'h03, 8'h1F, 8'h1D, 8'h2A, 8'h40, 8'h80, 8'h00};
	int          failures = 0, n_checks = 0;
	// Echo runs the sender into the transmit stream and grounds the pin
	assign rxd = route ? 1'b0 : line;
	assign txIn = route ? line : 1'b1;
	umcls_line_status i_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
		.wb_dat_i(wbDatW), .wb_ack_o(wbAck), .wb_dat_o(wbDatR),
		.baudTick(baudTick), .txSerialIn(txIn), .txHoldEmpty(txSt[3]),
		.txShiftEmpty(txSt[2]), .txIdle(txSt[1]), .txBreak(txSt[0]),
		.rxdPin(rxd), .ctsPinN(modemN[3]), .dsrPinN(modemN[2]),
		.dcdPinN(modemN[1]), .riPinN(modemN[0]), .txdPin(txdPin),
		.rtsPinN(rtsPinN), .dtrPinN(dtrPinN), .uartShutdown(shut),
		.multidropMode(mdrop));
	umcls_remote_model i_remote (.clk(clk), .baudTick(baudTick), .inv(inv),
		.go(go), .frame(frame), .nBits(nBits), .line(line), .busy(busy));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) baudTick <= !baudTick;
	task automatic finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatW <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (wbAck !== 1'b1) begin
			failures++;
			finish_test();
		end
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask
	task automatic send(input logic [13:0] f, input logic [3:0] nb);
		int n;
		n = 0;
		@(posedge clk);
		frame <= f;
		nBits <= nb;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy === 1'b1 && n < 600) begin
			@(posedge clk);
			n++;
		end
		if (n >= 600) begin
			failures++;
			finish_test();
		end
		// Pin synchroniser lag
		repeat (8) @(posedge clk);
	endtask
	function automatic logic [13:0] fr(input logic [7:0] d);
		return {4'h0, 1'b1, d, 1'b0};
	endfunction
	initial begin
		logic [7:0] v;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h10, 32'h00);
		rd(8'h14, 32'h60);
		rd(8'h40, 32'h00);
		rd(8'h18, 32'h10);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			txSt <= txCase[i];
			rd(8'h14, txExp[i]);
		end
		foreach (ctlSet[i]) begin
			v = ctlSet[i];
			wr(8'h10, {24'h0, v});
			@(posedge clk);
			check({27'h0, rtsPinN, dtrPinN, txdPin, shut, mdrop}, {27'h0, v[4] | !v[1], v[4] | !v[0], !v[6], v[7], v[5]});
			rd(8'h10, {24'h0, v});
			rd(8'h18, v[4] ? {24'h0, v[3], v[2], v[0], v[1], 4'h0} : 32'h10);
		end
		send(fr(8'h5A), 4'hA);
		rd(8'h14, 32'h61);
		rd(8'h00, 32'h5A);
		rd(8'h14, 32'h60);
		send(fr(8'h11), 4'hA);
		send(fr(8'h22), 4'hA);
		rd(8'h14, 32'h63);
		rd(8'h00, 32'h11);
		rd(8'h14, 32'h60);
		send(14'h14A, 4'hA);
		rd(8'h14, 32'hE9);
		rd(8'h14, 32'hE9);
		rd(8'h00, 32'hA5);
		rd(8'h14, 32'hE0);
		send(14'h0, 4'hE);
		rd(8'h14, 32'hF9);
		rd(8'h00, 32'h00);
		rd(8'h14, 32'hE0);
		wr(8'h10, 32'h80);
		wr(8'h0C, 32'h0B);
		wr(8'h10, 32'h00);
		send(14'h602, 4'hB);
		rd(8'h14, 32'hE5);
		rd(8'h00, 32'h01);
		send(14'h402, 4'hB);
		rd(8'h14, 32'hE1);
		wr(8'h10, 32'h80);
		wr(8'h0C, 32'h23);
		wr(8'h10, 32'h00);
		for (int i = 0; i < 17; i++)
			send(fr(8'h30 + 8'(i)), 4'hA);
		rd(8'h14, 32'h63);
		for (int i = 0; i < 16; i++)
			rd(8'h00, 32'h30 + i);
		rd(8'h14, 32'h60);
		send(fr(8'h77), 4'hA);
		wr(8'h10, 32'h80);
		rd(8'h14, 32'h60);
		rd(8'h00, 32'h00);
		wr(8'h10, 32'hC0);
		@(posedge clk);
		inv <= 1'b1;
		wr(8'h10, 32'h40);
		send(fr(8'h3C), 4'hA);
		rd(8'h14, 32'h61);
		rd(8'h00, 32'h3C);
		wr(8'h10, 32'h80);
		@(posedge clk);
		inv <= 1'b0;
		route <= 1'b1;
		wr(8'h10, 32'h10);
		send(fr(8'hC3), 4'hA);
		rd(8'h14, 32'h61);
		rd(8'h00, 32'hC3);
		finish_test();
	end
endmodule
`default_nettype wire
